/* File: core/rfls_pkg.sv */
package rfls_pkg;

  // ****************************************************
  // Sizes
  // ****************************************************
  localparam int          IDX_W     = 6;
  localparam int          DEPTH     = 64;
  localparam int          FREQ_W    = 32;
  localparam int          LEVEL_W   = 16;
  localparam int          DWELL_W   = 24;
  localparam int          HW_W      = FREQ_W + LEVEL_W;

  // ****************************************************
  // Register offsets (byte addresses)
  // ****************************************************
  localparam logic [7:0]  OFS_CTRL    = 8'h00;
  localparam logic [7:0]  OFS_CMD     = 8'h04;
  localparam logic [7:0]  OFS_GDWELL  = 8'h08;
  localparam logic [7:0]  OFS_RANGE   = 8'h0c;
  localparam logic [7:0]  OFS_INDEX   = 8'h10;
  localparam logic [7:0]  OFS_STATUS  = 8'h14;
  localparam logic [7:0]  OFS_TADDR   = 8'h18;
  localparam logic [7:0]  OFS_TFREQ   = 8'h1c;
  localparam logic [7:0]  OFS_TLEVEL  = 8'h20;
  localparam logic [7:0]  OFS_TDWELL  = 8'h24;

  // ****************************************************
  // Field positions
  // ****************************************************
  localparam int          CTRL_LIST   = 0;
  localparam int          CTRL_SWEEP  = 1;
  localparam int          CTRL_MODE   = 2;
  localparam int          CTRL_DWLIST = 5;
  localparam int          CTRL_LEARNED = 6;
  localparam int          CTRL_NEG    = 7;
  localparam int          CMD_RESET   = 0;
  localparam int          CMD_EXEC    = 1;
  localparam int          CMD_LEARN   = 2;
  localparam int          RANGE_STOP  = 8;

  // ****************************************************
  // Reset values and level clamp
  // ****************************************************
  localparam logic [DWELL_W-1:0] GDWELL_RST = 24'h0000ff;
  localparam logic [IDX_W-1:0]   STOP_RST   = 6'h3f;
  localparam logic [LEVEL_W-1:0] LEVEL_MAX  = 16'h7fff;

  // ****************************************************
  // Timing
  // ****************************************************
  localparam int          CLK_MHZ        = 25;
  localparam int          SETTLE_TIME_NS = 200;
  localparam int          SETTLE_CYCLES  = (SETTLE_TIME_NS * CLK_MHZ + 999) / 1000;
  localparam logic [2:0]  OVERRUN_LIMIT  = 3'h4;

  typedef enum logic [2:0] {
    MODE_AUTO, MODE_SINGLE, MODE_EXT_SINGLE, MODE_STEP, MODE_EXT_STEP
  } rfls_mode_t;

  typedef enum {ST_IDLE, ST_RUN, ST_WAIT, ST_LEARN} rfls_state_t;

endpackage : rfls_pkg

/* File: core/rfls_list_sequencer.sv */
`timescale 1ns/1ns
`default_nettype none
// Operation
// R1 - Enabling list mode starts processing list
// R2 - List and sweep enables are exclusive
// R3 - Step mode takes index; else reads current
// R4 - Auto mode advances on dwell expiry
// R5 - Switching to auto restarts at start
// R6 - Single mode: one pass per trigger
// R7 - Step mode: one entry per trigger
// R8 - Global dwell holds every entry
// R9 - List dwell uses per-entry value
// R10 - Significant overrun switches list mode off
// R11 - Learned mode replays stored settings
// R12 - Live mode computes settings per entry
// R13 - Slope applies to external trigger modes
// R14 - Positive slope: rising edge triggers
// R15 - Negative slope: falling edge triggers
// R16 - Reset command returns to start entry
// R17 - Execute command triggers single pass
// R18 - Start and stop index are configurable
// R19 - Only entries inside range are output
// R20 - Auto wraps from stop to start
module rfls_list_sequencer
  import rfls_pkg::*;
(
  input  wire logic                clock,
  input  wire logic                rst,
  input  wire logic                psel,
  input  wire logic                penable,
  input  wire logic                pwrite,
  input  wire logic [7:0]          paddr,
  input  wire logic [31:0]         pwdata,
  output logic      [31:0]         prdata,
  output logic                     pready,
  output logic                     pslverr,
  input  wire logic                extTrigger,
  output logic                     sweepEnable,
  output logic      [FREQ_W-1:0]   rfFreq,
  output logic      [LEVEL_W-1:0]  rfLevel,
  output logic                     rfUpdate
);

  // ****************************************************
  // Helpers
  // ****************************************************
  function automatic logic [HW_W-1:0] calcHw(logic [FREQ_W-1:0] f,
                                             logic [LEVEL_W-1:0] l);
    logic [LEVEL_W-1:0] lv;
    lv = ($signed(l) > $signed(LEVEL_MAX)) ? LEVEL_MAX : l;
    calcHw = {f, lv};
  endfunction : calcHw

  function automatic logic [IDX_W-1:0] clampIdx(logic [IDX_W-1:0] i,
                                                logic [IDX_W-1:0] lo,
                                                logic [IDX_W-1:0] hi);
    clampIdx = (i < lo) ? lo : ((i > hi) ? hi : i);
  endfunction : clampIdx

  // ****************************************************
  // Storage
  // ****************************************************
  logic [FREQ_W-1:0]  freqMem    [DEPTH];
  logic [LEVEL_W-1:0] levelMem   [DEPTH];
  logic [DWELL_W-1:0] dwellMem   [DEPTH];
  logic [HW_W-1:0]    learnedMem [DEPTH];

  logic                listEnable_reg;
  logic                sweepEnable_reg;
  rfls_mode_t          mode_reg;
  rfls_mode_t          modePrev_reg;
  logic                dwellFromList_reg;
  logic                runLearned_reg;
  logic                slopeNeg_reg;
  logic [DWELL_W-1:0]  globalDwell_reg;
  logic [IDX_W-1:0]    rangeStart_reg;
  logic [IDX_W-1:0]    rangeStop_reg;
  logic [IDX_W-1:0]    tabAddr_reg;
  logic [IDX_W-1:0]    curIdx_reg;
  logic [IDX_W-1:0]    idxNext;
  logic [IDX_W-1:0]    learnIdx_reg;
  logic [DWELL_W-1:0]  dwellCnt_reg;
  logic [2:0]          overrunCnt_reg;
  logic                overrunOff_reg;
  logic                learnedValid_reg;
  logic                trigSync1_reg;
  logic                trigSync2_reg;
  logic                trigPrev_reg;
  logic [31:0]         prdata_reg;
  rfls_state_t         state_reg;
  rfls_state_t         stateNext;
  logic                load;
  logic                wrEn;
  logic                resetCmd;
  logic                execCmd;
  logic                learnCmd;
  logic                idxWrite;
  logic                extEdge;
  logic                trig;
  logic                extMode;
  logic                stepMode;
  logic                singleMode;
  logic                toAuto;
  logic                expire;
  logic                overrunHit;
  logic [IDX_W-1:0]    stepIdx;
  logic [DWELL_W-1:0]  dwellSel;

  // ****************************************************
  // APB slave
  // ****************************************************
  assign pready  = 1'b1;
  assign pslverr = psel && penable && (paddr > OFS_TDWELL || paddr[1:0] != 2'b00);
  assign wrEn    = psel && penable && pwrite && !pslverr;
  assign prdata  = prdata_reg;

  assign resetCmd = wrEn && paddr == OFS_CMD && pwdata[CMD_RESET];
  assign execCmd  = wrEn && paddr == OFS_CMD && pwdata[CMD_EXEC];
  assign learnCmd = wrEn && paddr == OFS_CMD && pwdata[CMD_LEARN];
  assign idxWrite = wrEn && paddr == OFS_INDEX;

  // Read data is captured in the setup cycle, so no wait state is needed
  always_ff @(posedge clock)
  begin
    if (rst)
      prdata_reg <= 32'h0;
    else if (psel && !penable && !pwrite)
    begin
      case (paddr)
        OFS_CTRL:   prdata_reg <= {24'h0, slopeNeg_reg, runLearned_reg,
                                   dwellFromList_reg, mode_reg,
                                   sweepEnable_reg, listEnable_reg};
        OFS_GDWELL: prdata_reg <= {8'h0, globalDwell_reg};
        OFS_RANGE:  prdata_reg <= {18'h0, rangeStop_reg, 2'h0, rangeStart_reg};
        OFS_INDEX:  prdata_reg <= {26'h0, curIdx_reg};              // [R3]
        OFS_STATUS: prdata_reg <= {27'h0, overrunOff_reg, learnedValid_reg,
                                   state_reg == ST_LEARN,
                                   state_reg == ST_WAIT,
                                   state_reg == ST_RUN};
        OFS_TADDR:  prdata_reg <= {26'h0, tabAddr_reg};
        OFS_TFREQ:  prdata_reg <= freqMem[tabAddr_reg];
        OFS_TLEVEL: prdata_reg <= {16'h0, levelMem[tabAddr_reg]};
        OFS_TDWELL: prdata_reg <= {8'h0, dwellMem[tabAddr_reg]};
        default:    prdata_reg <= 32'h0;
      endcase
    end
  end

  // ****************************************************
  // Configuration registers
  // ****************************************************
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      listEnable_reg  <= 1'b0;
      sweepEnable_reg <= 1'b0;
    end
    else if (overrunHit)
      listEnable_reg <= 1'b0;                                       // [R10]
    else if (wrEn && paddr == OFS_CTRL)
    begin
      // List wins if both are requested in one write
      listEnable_reg  <= pwdata[CTRL_LIST];                         // [R1]
      sweepEnable_reg <= pwdata[CTRL_SWEEP] && !pwdata[CTRL_LIST];  // [R2]
    end
  end

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      mode_reg          <= MODE_AUTO;
      dwellFromList_reg <= 1'b0;
      runLearned_reg    <= 1'b0;
      slopeNeg_reg      <= 1'b0;
      globalDwell_reg   <= GDWELL_RST;
      rangeStart_reg    <= '0;
      rangeStop_reg     <= STOP_RST;
      tabAddr_reg       <= '0;
    end
    else if (wrEn)
    begin
      case (paddr)
        OFS_CTRL:
        begin
          if (pwdata[CTRL_MODE+2:CTRL_MODE] <= 3'(MODE_EXT_STEP))
            mode_reg <= rfls_mode_t'(pwdata[CTRL_MODE+2:CTRL_MODE]);
          dwellFromList_reg <= pwdata[CTRL_DWLIST];
          runLearned_reg    <= pwdata[CTRL_LEARNED];
          slopeNeg_reg      <= pwdata[CTRL_NEG];
        end
        OFS_GDWELL: globalDwell_reg <= pwdata[DWELL_W-1:0];
        OFS_RANGE:
        begin
          rangeStart_reg <= pwdata[IDX_W-1:0];                      // [R18]
          rangeStop_reg  <= pwdata[RANGE_STOP+IDX_W-1:RANGE_STOP];  // [R18]
        end
        OFS_TADDR:  tabAddr_reg <= pwdata[IDX_W-1:0];
        default:    ;
      endcase
    end
  end

  always_ff @(posedge clock)
  begin
    if (wrEn && paddr == OFS_TFREQ)
      freqMem[tabAddr_reg] <= pwdata;
    if (wrEn && paddr == OFS_TLEVEL)
      levelMem[tabAddr_reg] <= pwdata[LEVEL_W-1:0];
    if (wrEn && paddr == OFS_TDWELL)
      dwellMem[tabAddr_reg] <= pwdata[DWELL_W-1:0];
    if (state_reg == ST_LEARN)
      learnedMem[learnIdx_reg] <= calcHw(freqMem[learnIdx_reg],
                                         levelMem[learnIdx_reg]);
  end

  // ****************************************************
  // External trigger
  // ****************************************************
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      trigSync1_reg <= 1'b0;
      trigSync2_reg <= 1'b0;
      trigPrev_reg  <= 1'b0;
    end
    else
    begin
      trigSync1_reg <= extTrigger;
      trigSync2_reg <= trigSync1_reg;
      trigPrev_reg  <= trigSync2_reg;
    end
  end

  assign extEdge = slopeNeg_reg ? (trigPrev_reg && !trigSync2_reg)  // [R15]
                                : (!trigPrev_reg && trigSync2_reg); // [R14]
  assign extMode    = mode_reg == MODE_EXT_SINGLE || mode_reg == MODE_EXT_STEP;
  assign stepMode   = mode_reg == MODE_STEP || mode_reg == MODE_EXT_STEP;
  assign singleMode = mode_reg == MODE_SINGLE || mode_reg == MODE_EXT_SINGLE;
  assign trig       = extMode ? extEdge : execCmd;                  // [R13] [R17]
  assign toAuto     = mode_reg == MODE_AUTO && modePrev_reg != MODE_AUTO;
  assign expire     = state_reg == ST_RUN && dwellCnt_reg == 24'h1;
  // Below-range index jumps to start, so no outside entry plays
  assign stepIdx    = (curIdx_reg >= rangeStop_reg
                       || curIdx_reg < rangeStart_reg)
                      ? rangeStart_reg                        // [R20] [R19]
                      : curIdx_reg + 6'h1;                    // [R20]

  // ****************************************************
  // Sequencer
  // ****************************************************
  always_comb
  begin
    stateNext = state_reg;
    idxNext   = curIdx_reg;
    load      = 1'b0;
    case (state_reg)
      ST_IDLE:
        if (listEnable_reg)
        begin
          idxNext   = rangeStart_reg;                               // [R1]
          load      = 1'b1;
          stateNext = (mode_reg == MODE_AUTO) ? ST_RUN : ST_WAIT;
        end
        else if (learnCmd)
          stateNext = ST_LEARN;
      ST_RUN, ST_WAIT:
        if (!listEnable_reg)
          stateNext = ST_IDLE;
        else if (toAuto || resetCmd)
        begin
          idxNext   = rangeStart_reg;                               // [R5] [R16]
          load      = 1'b1;
          stateNext = (mode_reg == MODE_AUTO) ? ST_RUN : ST_WAIT;
        end
        else if (stepMode)
        begin
          stateNext = ST_WAIT;                                      // [R7]
          if (trig)
          begin
            idxNext = stepIdx;                                      // [R7]
            load    = 1'b1;
          end
          else if (idxWrite)
          begin
            idxNext = clampIdx(pwdata[IDX_W-1:0], rangeStart_reg,
                               rangeStop_reg);                      // [R3] [R19]
            load    = 1'b1;
          end
        end
        else if (state_reg == ST_WAIT)
        begin
          if (singleMode && trig)
          begin
            idxNext   = rangeStart_reg;                             // [R6]
            load      = 1'b1;
            stateNext = ST_RUN;
          end
        end
        else if (expire)
        begin
          if (singleMode && curIdx_reg >= rangeStop_reg)
            stateNext = ST_WAIT;                                    // [R6]
          else
          begin
            idxNext = stepIdx;                                      // [R4] [R19]
            load    = 1'b1;
          end
        end
      ST_LEARN:
        if (learnIdx_reg == IDX_W'(DEPTH - 1))
          stateNext = ST_IDLE;
      default:
        stateNext = ST_IDLE;
    endcase
  end

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      state_reg    <= ST_IDLE;
      curIdx_reg   <= '0;
      modePrev_reg <= MODE_AUTO;
      learnIdx_reg <= '0;
    end
    else
    begin
      state_reg    <= stateNext;
      curIdx_reg   <= idxNext;
      modePrev_reg <= mode_reg;
      learnIdx_reg <= (state_reg == ST_LEARN) ? learnIdx_reg + 6'h1 : '0;
    end
  end

  // Learned data goes stale once a table frequency or level is edited
  always_ff @(posedge clock)
  begin
    if (rst)
      learnedValid_reg <= 1'b0;
    else if (state_reg == ST_LEARN && stateNext == ST_IDLE)
      learnedValid_reg <= 1'b1;
    else if (wrEn && (paddr == OFS_TFREQ || paddr == OFS_TLEVEL))
      learnedValid_reg <= 1'b0;
  end

  // ****************************************************
  // Dwell timing and overrun
  // ****************************************************
  assign dwellSel = dwellFromList_reg ? dwellMem[idxNext]            // [R9]
                                      : globalDwell_reg;             // [R8]
  assign overrunHit = overrunCnt_reg == OVERRUN_LIMIT;

  always_ff @(posedge clock)
  begin
    if (rst)
      dwellCnt_reg <= 24'h1;
    else if (load)
      dwellCnt_reg <= (dwellSel == 24'h0) ? 24'h1 : dwellSel;
    else if (state_reg == ST_RUN && dwellCnt_reg != 24'h1)
      dwellCnt_reg <= dwellCnt_reg - 24'h1;
  end

  // Live computing cannot settle faster than the hardware path
  always_ff @(posedge clock)
  begin
    if (rst || overrunHit || !listEnable_reg)
      overrunCnt_reg <= 3'h0;
    else if (load && stateNext == ST_RUN && !runLearned_reg)
      overrunCnt_reg <= (dwellSel < DWELL_W'(SETTLE_CYCLES))
                        ? overrunCnt_reg + 3'h1 : 3'h0;
  end

  always_ff @(posedge clock)
  begin
    if (rst)
      overrunOff_reg <= 1'b0;
    else if (overrunHit)
      overrunOff_reg <= 1'b1;
    else if (wrEn && paddr == OFS_CTRL && pwdata[CTRL_LIST])
      overrunOff_reg <= 1'b0;
  end

  // ****************************************************
  // RF settings output
  // ****************************************************
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      rfFreq   <= '0;
      rfLevel  <= '0;
      rfUpdate <= 1'b0;
    end
    else
    begin
      rfUpdate <= load;
      if (load)
      begin
        if (runLearned_reg)
          {rfFreq, rfLevel} <= learnedMem[idxNext];                 // [R11]
        else
          {rfFreq, rfLevel} <= calcHw(freqMem[idxNext],
                                      levelMem[idxNext]);           // [R12]
      end
    end
  end

  assign sweepEnable = sweepEnable_reg;

  // ****************************************************
  // Checks
  // ****************************************************
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  property p_excl;
    !(listEnable_reg && sweepEnable_reg);
  endproperty
  a_excl: assert property (p_excl) else $error("list and sweep both on"); // [R2]

  property p_auto_restart;
    (listEnable_reg && state_reg != ST_IDLE && toAuto)
      |=> (curIdx_reg == $past(rangeStart_reg)) && rfUpdate;
  endproperty
  a_auto_restart: assert property (p_auto_restart) else $error("auto restart"); // [R5]

  property p_auto_advance;
    (state_reg == ST_RUN && mode_reg == MODE_AUTO && expire && listEnable_reg
     && !toAuto && !resetCmd) |=> rfUpdate && curIdx_reg != $past(curIdx_reg)
                                  || $past(rangeStart_reg == rangeStop_reg);
  endproperty
  a_auto_advance: assert property (p_auto_advance) else $error("no advance"); // [R4]

  sequence s_step_trig;
    listEnable_reg && state_reg == ST_WAIT && stepMode && trig
      && !toAuto && !resetCmd;
  endsequence
  property p_step;
    s_step_trig |=> curIdx_reg == $past(stepIdx) ##1 !rfUpdate;
  endproperty
  a_step: assert property (p_step) else $error("step mismatch"); // [R7]

  property p_overrun;
    overrunHit |=> !listEnable_reg && overrunOff_reg;
  endproperty
  a_overrun: assert property (p_overrun) else $error("overrun kept list"); // [R10]

  property p_range;
    (state_reg != ST_IDLE && state_reg != ST_LEARN
     && rangeStart_reg <= rangeStop_reg && $stable(rangeStart_reg)
     && $stable(rangeStop_reg) && $past(load))
      |-> curIdx_reg >= rangeStart_reg && curIdx_reg <= rangeStop_reg;
  endproperty
  a_range: assert property (p_range) else $error("index out of range"); // [R19]

  property p_reset_cmd;
    (listEnable_reg && state_reg != ST_IDLE && state_reg != ST_LEARN
     && resetCmd) |=> curIdx_reg == $past(rangeStart_reg);
  endproperty
  a_reset_cmd: assert property (p_reset_cmd) else $error("reset ignored"); // [R16]

  sequence s_pass_end;
    state_reg == ST_RUN && singleMode && expire && listEnable_reg
      && curIdx_reg >= rangeStop_reg && !resetCmd && !toAuto;
  endsequence
  property p_single_wait;
    s_pass_end |=> state_reg == ST_WAIT ##1 (state_reg == ST_WAIT || $past(trig));
  endproperty
  a_single_wait: assert property (p_single_wait) else $error("no wait"); // [R6]

  property p_ext_rise;
    (extMode && !slopeNeg_reg && state_reg == ST_WAIT && listEnable_reg
     && !trigPrev_reg && trigSync2_reg) |=> rfUpdate;
  endproperty
  a_ext_rise: assert property (p_ext_rise) else $error("rise missed"); // [R14]

  property p_ext_fall;
    (extMode && slopeNeg_reg && state_reg == ST_WAIT && listEnable_reg
     && trigPrev_reg && !trigSync2_reg) |=> rfUpdate;
  endproperty
  a_ext_fall: assert property (p_ext_fall) else $error("fall missed"); // [R15]

  property p_ext_wrong;
    (extMode && slopeNeg_reg && state_reg == ST_WAIT && listEnable_reg
     && !resetCmd && !idxWrite && !trigPrev_reg && trigSync2_reg)
      |=> !rfUpdate;
  endproperty
  a_ext_wrong: assert property (p_ext_wrong) else $error("bad edge"); // [R15]

endmodule : rfls_list_sequencer
`default_nettype wire

/* File: tb/rfls_trig_src.sv */
`timescale 1ns/1ns
`default_nettype none
module rfls_trig_src
(
  input  wire logic clock,
  input  wire logic negSlope,
  input  wire logic fire,
  output logic      extTrigger
);
  logic [2:0] holdCnt = 3'h0;

  // Active level held 4 cycles, long enough for a 2-flop sync
  always @(posedge clock)
    if (fire)
      holdCnt <= 3'h4;
    else if (holdCnt != 3'h0)
      holdCnt <= holdCnt - 3'h1;

  // Idle at the inactive level, so only one active edge per fire
  assign extTrigger = (holdCnt != 3'h0) ? ~negSlope : negSlope;
endmodule : rfls_trig_src
`default_nettype wire

/* File: tb/test_rf_list_step_sequencer.sv */
`timescale 1ns/1ns
`default_nettype none
module test_rf_list_step_sequencer
  import rfls_pkg::*;
;
  logic               clock = 1'b0;
  logic               rst = 1'b1;
  logic               psel = 1'b0;
  logic               penable = 1'b0;
  logic               pwrite = 1'b0;
  logic [7:0]         paddr = 8'h00;
  logic [31:0]        pwdata = 32'h0;
  logic [31:0]        prdata, rd;
  logic               pready, pslverr, err, extTrigger, sweepEnable;
  logic               rfUpdate;
  logic               negSlope = 1'b0;
  logic               fire = 1'b0;
  logic [FREQ_W-1:0]  rfFreq;
  logic [LEVEL_W-1:0] rfLevel;
  int                 num_errors = 0;
  int                 check_count = 0;
  int                 gap;

  rfls_list_sequencer u_dut (.clock(clock), .rst(rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .extTrigger(extTrigger), .sweepEnable(sweepEnable), .rfFreq(rfFreq),
    .rfLevel(rfLevel), .rfUpdate(rfUpdate));
  rfls_trig_src u_src (.clock(clock), .negSlope(negSlope), .fire(fire),
    .extTrigger(extTrigger));

  initial forever #20 clock = ~clock;

  // ******************
  // Bus and checks
  // ******************
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    check_count++;
    if (g !== e)
    begin
      num_errors++;
      $display("[FAIL] %s exp %h got %h", nm, e, g);
    end
  endtask : chk

  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge clock);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    do @(posedge clock); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic rdchk(input string nm, input logic [7:0] a,
                       input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(nm, e, rd);
  endtask : rdchk

  // Level was loaded as freq minus one, so both halves are checked
  task automatic upd(input logic [31:0] e, input int lim);
    gap = 0;
    do
    begin
      @(negedge clock);
      gap++;
    end while (rfUpdate !== 1'b1 && gap < lim);
    chk("rfUpdate", 32'h1, rfUpdate);
    chk("rfFreq", e, rfFreq);
    chk("rfLevel", e - 32'h1, {16'h0, rfLevel});
  endtask : upd

  task automatic quiet(input int n);
    int c;
    c = 0;
    repeat (n)
    begin
      @(negedge clock);
      if (rfUpdate === 1'b1)
        c++;
    end
    chk("extra updates", 32'h0, c);
  endtask : quiet

  task automatic pulse();
    @(posedge clock);
    fire <= 1'b1;
    @(posedge clock);
    fire <= 1'b0;
  endtask : pulse

  task automatic stop_test();
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : stop_test

  // ******************
  // Scenarios
  // ******************
  task automatic t_regs();
    rdchk("ctrl", OFS_CTRL, 32'h0);
    rdchk("gdwell", OFS_GDWELL, 32'h0000ff);
    rdchk("range", OFS_RANGE, 32'h3f00);
    apb(1'b0, 8'h28, 32'h0);
    chk("pslverr", 32'h1, err);
    chk("unmapped", 32'h0, rd);
    for (int i = 0; i < 4; i++)
    begin
      apb(1'b1, OFS_TADDR, i);
      apb(1'b1, OFS_TFREQ, i + 1);
      apb(1'b1, OFS_TLEVEL, i);
      apb(1'b1, OFS_TDWELL, 3 * i + 3);
    end
    apb(1'b1, OFS_RANGE, 32'h0301);
    apb(1'b1, OFS_GDWELL, 32'h8);
    $display("test regs done");
  endtask : t_regs

  task automatic t_sweep();
    apb(1'b1, OFS_CTRL, 32'h2);
    @(negedge clock);
    chk("sweep on", 32'h1, sweepEnable);
    apb(1'b1, OFS_CTRL, 32'h3);
    rdchk("ctrl", OFS_CTRL, 32'h1);
    chk("sweep off", 32'h0, sweepEnable);
    apb(1'b1, OFS_CTRL, 32'h0);
    $display("test sweep done");
  endtask : t_sweep

  task automatic t_step();
    apb(1'b1, OFS_CTRL, 32'hd);
    upd(2, 20);
    apb(1'b1, OFS_INDEX, 32'h3);
    upd(4, 20);
    rdchk("index", OFS_INDEX, 32'h3);
    apb(1'b1, OFS_CMD, 32'h2);
    upd(2, 20);
    apb(1'b1, OFS_CMD, 32'h2);
    upd(3, 20);
    apb(1'b1, OFS_CMD, 32'h1);
    upd(2, 20);
    quiet(40);
    $display("test step done");
  endtask : t_step

  task automatic t_auto(input logic [31:0] c, input int d1, d2, d3);
    apb(1'b1, OFS_CTRL, 32'hd);
    apb(1'b1, OFS_INDEX, 32'h3);
    repeat (8) @(posedge clock);
    apb(1'b1, OFS_CTRL, c);
    upd(2, 20);
    upd(3, 40);
    chk("dwell1", d1, gap);
    upd(4, 40);
    chk("dwell2", d2, gap);
    upd(2, 40);
    chk("dwell3", d3, gap);
    $display("test auto done");
  endtask : t_auto

  task automatic t_single();
    apb(1'b1, OFS_CTRL, 32'h5);
    // Running pass from the auto test must finish first
    repeat (30) @(posedge clock);
    for (int p = 0; p < 2; p++)
    begin
      apb(1'b1, OFS_CMD, 32'h2);
      upd(2, 20);
      upd(3, 40);
      upd(4, 40);
      quiet(40);
    end
    apb(1'b0, OFS_STATUS, 32'h0);
    chk("waiting", 32'h1, rd[1]);
    $display("test single done");
  endtask : t_single

  task automatic t_ext(input logic neg, input logic [2:0] md,
                       input logic [31:0] e);
    apb(1'b1, OFS_CTRL, {24'h0, neg, 2'b00, md, 2'b01});
    apb(1'b1, OFS_INDEX, 32'h1);
    repeat (8) @(posedge clock);
    negSlope <= neg;
    quiet(20);
    pulse();
    upd(e, 20);
    // External single plays the rest of the pass before waiting
    if (md == 3'h2)
    begin
      upd(3, 40);
      upd(4, 40);
    end
    quiet(30);
    $display("test ext done");
  endtask : t_ext

  task automatic t_overrun();
    apb(1'b1, OFS_GDWELL, 32'h2);
    apb(1'b1, OFS_CTRL, 32'h1);
    repeat (60) @(posedge clock);
    apb(1'b0, OFS_CTRL, 32'h0);
    chk("list on", 32'h0, rd[0]);
    apb(1'b0, OFS_STATUS, 32'h0);
    chk("overrun", 32'h1, rd[4]);
    apb(1'b1, OFS_GDWELL, 32'h8);
    $display("test overrun done");
  endtask : t_overrun

  task automatic t_learn();
    apb(1'b1, OFS_CTRL, 32'h0);
    apb(1'b1, OFS_CMD, 32'h4);
    repeat (80) @(posedge clock);
    apb(1'b1, OFS_TADDR, 32'h1);
    apb(1'b1, OFS_TFREQ, 32'h5);
    apb(1'b1, OFS_TLEVEL, 32'h4);
    apb(1'b1, OFS_CTRL, 32'h4d);
    upd(2, 20);
    apb(1'b1, OFS_CTRL, 32'hd);
    repeat (8) @(posedge clock);
    apb(1'b1, OFS_INDEX, 32'h2);
    upd(3, 20);
    apb(1'b1, OFS_INDEX, 32'h1);
    upd(5, 20);
    $display("test learn done");
  endtask : t_learn

  initial
  begin
    repeat (10) @(posedge clock);
    rst <= 1'b0;
    t_regs();
    t_sweep();
    t_step();
    t_auto(32'h1, 8, 8, 8);
    t_auto(32'h21, 6, 9, 12);
    t_single();
    t_ext(1'b0, 3'h4, 3);
    t_ext(1'b1, 3'h2, 2);
    t_overrun();
    t_learn();
    stop_test();
  end

  // Whole run is under a thousand cycles
  initial
  begin
    repeat (20000) @(posedge clock);
    num_errors++;
    stop_test();
  end
endmodule : test_rf_list_step_sequencer
`default_nettype wire
